/* File: hdl/scr_pkg.sv */
// package: register map, field positions and timing constants of the slot-0 register bank
package scr_pkg;
   // internal map, byte addresses
   localparam logic [5:0] OFS_CONTROL_STATUS      = 6'h00;
   localparam logic [5:0] OFS_BURST_LENGTH_LIMIT  = 6'h04;
   localparam logic [5:0] OFS_TRIGGER_DELAY_COUNT = 6'h08;
   localparam logic [5:0] OFS_TRANSFER_COUNT      = 6'h0c;
   localparam logic [5:0] OFS_DEMAND_QUEUE_READ   = 6'h14;
   localparam logic [5:0] OFS_IRQ_HANDLER_MASK    = 6'h18;
   localparam logic [5:0] OFS_TRIGGER_SOURCE      = 6'h20;
   localparam logic [5:0] OFS_BCAST_TRIGGER_MASK  = 6'h24;
   // configuration space offsets
   localparam logic [5:0] OFS_SUFFIX_HIGH         = 6'h20;
   localparam logic [5:0] OFS_SUFFIX_LOW          = 6'h22;
   // control_status bit positions
   localparam int BIT_SELFTEST_OK      = 15;
   localparam int BIT_DEMAND_OVERFLOW  = 12;
   localparam int BIT_DEMAND_FLUSH     = 11;
   localparam int BIT_DEMAND_PENDING   = 10;
   localparam int BIT_DEMAND_MSG_EN    = 9;
   localparam int BIT_IRQ_DEMAND_EN    = 7;
   localparam int BIT_TRIG_DELAY_EN    = 5;
   localparam int BIT_BURST_EN         = 4;
   localparam int BIT_FAIL_DRIVE       = 2;
   localparam int BIT_FAIL_SENSE       = 1;
   localparam int BIT_RESET_PULSE      = 0;
   // sizes
   localparam int DEMAND_DEPTH         = 2048;
   localparam int DEMAND_WIDTH         = 4;
   localparam int BURST_FIELD_W        = 8;
   // backplane reset pulse width
   localparam int RESET_PULSE_NS       = 200;
   localparam int CLK_PERIOD_NS        = 10;
   localparam int RESET_PULSE_CYC      = (RESET_PULSE_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
   localparam logic [31:0] REG_ZERO    = 32'h0000_0000;
endpackage : scr_pkg

/* File: hdl/scr_dq_if.sv */
// interface: push/pop/flush link between the register bank and the demand queue
`timescale 1ns/1ns
`default_nettype none
interface scr_dq_if #(parameter int W = 4, parameter int DEPTH = 2048);
   logic          push;
   logic [W-1:0]  push_data;
   logic          pop;
   logic          flush;
   logic [W-1:0]  head;
   logic          nonempty;
   logic          full;
   modport owner (output push, output push_data, output pop, output flush,
                  input head, input nonempty, input full);
   modport queue (input push, input push_data, input pop, input flush,
                  output head, output nonempty, output full);
endinterface : scr_dq_if
`default_nettype wire

/* File: hdl/scr_demand_queue.sv */
// demand queue: circular array of interrupt levels with flush
`timescale 1ns/1ns
`default_nettype none
module scr_demand_queue #(
   parameter int W     = 4,
   parameter int DEPTH = 2048
) (
   // clock and reset
   input  wire logic ref_clk,
   input  wire logic rst,
   input  wire logic clk_en,
   // queue side
   scr_dq_if.queue   q
);
   localparam int AW = $clog2(DEPTH);
   logic [W-1:0]  mem [DEPTH];
   logic [AW-1:0] wr_r, wr_nxt, rd_r, rd_nxt;
   logic [AW:0]   cnt_r, cnt_nxt;
   logic          do_push, do_pop;

   always_comb begin
      do_push = q.push && (cnt_r != (AW+1)'(DEPTH)) && !q.flush;
      do_pop  = q.pop && (cnt_r != '0) && !q.flush;
      wr_nxt  = do_push ? wr_r + AW'(1) : wr_r;
      rd_nxt  = do_pop ? rd_r + AW'(1) : rd_r;
      cnt_nxt = cnt_r + (AW+1)'(do_push) - (AW+1)'(do_pop);
      if (q.flush) begin
         wr_nxt  = '0;
         rd_nxt  = '0;
         cnt_nxt = '0;
      end
   end

   always_ff @(posedge ref_clk or posedge rst) begin
      if (rst) begin
         wr_r  <= '0;
         rd_r  <= '0;
         cnt_r <= '0;
      end else if (clk_en) begin
         wr_r  <= wr_nxt;
         rd_r  <= rd_nxt;
         cnt_r <= cnt_nxt;
      end
   end

   // array kept out of reset so it can map to block memory
   always_ff @(posedge ref_clk) begin
      if (clk_en && do_push) begin
         mem[wr_r] <= q.push_data;
      end
   end

   assign q.head     = mem[rd_r];
   assign q.nonempty = (cnt_r != '0);
   assign q.full     = (cnt_r == (AW+1)'(DEPTH));
endmodule : scr_demand_queue
`default_nettype wire

/* File: hdl/scr_regs.sv */
// slot-0 controller register bank: control/status, burst limit, demand queue, suffix identity
`timescale 1ns/1ns
`default_nettype none
module scr_regs #(
   parameter logic [15:0] SUFFIX_HIGH = 16'h5858, // arbitrary identity value
   parameter logic [15:0] SUFFIX_LOW  = 16'h3030, // arbitrary identity value
   parameter int          DEPTH       = scr_pkg::DEMAND_DEPTH
) (
   // clock, reset, enable
   input  wire logic        ref_clk,
   input  wire logic        rst,
   input  wire logic        clk_en,
   // internal register port
   input  wire logic        reg_wr,
   input  wire logic        reg_rd,
   input  wire logic [5:0]  reg_addr,
   input  wire logic [31:0] reg_wdata,
   output logic      [31:0] reg_rdata,
   // configuration space read port
   input  wire logic        cfg_rd,
   input  wire logic [5:0]  cfg_addr,
   output logic      [15:0] cfg_rdata,
   // device state
   input  wire logic        selftest_ok,
   input  wire logic        irq_valid,
   input  wire logic [2:0]  irq_level,
   input  wire logic        fail_line_in,
   input  wire logic [31:0] transfer_count_remaining,
   input  wire logic        demand_msg_taken,
   // control outputs
   output logic             demand_msg_req,
   output logic [3:0]       demand_msg_src,
   output logic             trigger_delay_enable,
   output logic             burst_enable,
   output logic [7:0]       burst_length_limit,
   output logic [15:0]      trigger_delay_count,
   output logic [31:0]      irq_handler_mask,
   output logic [31:0]      trigger_source_select,
   output logic [31:0]      broadcast_trigger_mask,
   output logic             fail_line_drive_n,
   output logic             backplane_reset_pulse
);
   localparam int PCW = $clog2(scr_pkg::RESET_PULSE_CYC + 1);

   scr_dq_if #(.W(scr_pkg::DEMAND_WIDTH), .DEPTH(DEPTH)) dq ();

   scr_demand_queue #(.W(scr_pkg::DEMAND_WIDTH), .DEPTH(DEPTH)) u_queue (
      .ref_clk (ref_clk),
      .rst     (rst),
      .clk_en  (clk_en),
      .q       (dq)
   );

   // pin input synchronisers (fail line, self-test strap)
   logic fail_s1_r;
   logic fail_s2_r;
   logic st_s1_r;
   logic st_s2_r;
   always_ff @(posedge ref_clk or posedge rst) begin
      if (rst) begin
         fail_s1_r <= 1'b0;
         fail_s2_r <= 1'b0;
         st_s1_r   <= 1'b0;
         st_s2_r   <= 1'b0;
      end else if (clk_en) begin
         fail_s1_r <= fail_line_in;
         fail_s2_r <= fail_s1_r;
         st_s1_r   <= selftest_ok;
         st_s2_r   <= st_s1_r;
      end
   end

   // register state
   logic           msg_en_r;
   logic           msg_en_nxt;
   logic           irq_en_r;
   logic           irq_en_nxt;
   logic           dly_en_r;
   logic           dly_en_nxt;
   logic           bst_en_r;
   logic           bst_en_nxt;
   logic           fail_r;
   logic           fail_nxt;
   logic           ovf_r;
   logic           ovf_nxt;
   logic [7:0]     bct_r;
   logic [7:0]     bct_nxt;
   logic [15:0]    dct_r;
   logic [15:0]    dct_nxt;
   logic [31:0]    ihm_r;
   logic [31:0]    ihm_nxt;
   logic [31:0]    tsr_r;
   logic [31:0]    tsr_nxt;
   logic [31:0]    btm_r;
   logic [31:0]    btm_nxt;
   logic [PCW-1:0] rst_cnt_r;
   logic [PCW-1:0] rst_cnt_nxt;
   logic           rst_out_r;
   logic           rst_out_nxt;
   logic           msg_req_r;
   logic           msg_req_nxt;
   logic [3:0]     msg_src_r;
   logic [3:0]     msg_src_nxt;
   logic [31:0]    rdata_r;
   logic [31:0]    rdata_nxt;
   logic [15:0]    cdata_r;
   logic [15:0]    cdata_nxt;
   logic           csr_wr;
   logic           flush;
   logic [15:0]    csr_view;

   always_comb begin
      csr_wr = reg_wr && (reg_addr == scr_pkg::OFS_CONTROL_STATUS);
      flush  = csr_wr && reg_wdata[scr_pkg::BIT_DEMAND_FLUSH];
      msg_en_nxt = msg_en_r;
      irq_en_nxt = irq_en_r;
      dly_en_nxt = dly_en_r;
      bst_en_nxt = bst_en_r;
      fail_nxt   = fail_r;
      if (csr_wr) begin
         msg_en_nxt = reg_wdata[scr_pkg::BIT_DEMAND_MSG_EN];
         irq_en_nxt = reg_wdata[scr_pkg::BIT_IRQ_DEMAND_EN];
         dly_en_nxt = reg_wdata[scr_pkg::BIT_TRIG_DELAY_EN];
         bst_en_nxt = reg_wdata[scr_pkg::BIT_BURST_EN];
         fail_nxt   = reg_wdata[scr_pkg::BIT_FAIL_DRIVE];
      end
      bct_nxt = bct_r;
      dct_nxt = dct_r;
      ihm_nxt = ihm_r;
      tsr_nxt = tsr_r;
      btm_nxt = btm_r;
      if (reg_wr) begin
         case (reg_addr)
            scr_pkg::OFS_BURST_LENGTH_LIMIT:  bct_nxt = reg_wdata[scr_pkg::BURST_FIELD_W-1:0];
            scr_pkg::OFS_TRIGGER_DELAY_COUNT: dct_nxt = reg_wdata[15:0];
            scr_pkg::OFS_IRQ_HANDLER_MASK:    ihm_nxt = reg_wdata;
            scr_pkg::OFS_TRIGGER_SOURCE:      tsr_nxt = reg_wdata;
            scr_pkg::OFS_BCAST_TRIGGER_MASK:  btm_nxt = reg_wdata;
            default: ;
         endcase
      end
   end

   always_ff @(posedge ref_clk or posedge rst) begin
      if (rst) begin
         msg_en_r <= 1'b0;
         irq_en_r <= 1'b0;
         dly_en_r <= 1'b0;
         bst_en_r <= 1'b0;
         fail_r   <= 1'b0;
         bct_r    <= 8'h00;
         dct_r    <= 16'h0000;
         ihm_r    <= 32'h0000_0000;
         tsr_r    <= 32'h0000_0000;
         btm_r    <= 32'h0000_0000;
      end else if (clk_en) begin
         msg_en_r <= msg_en_nxt;
         irq_en_r <= irq_en_nxt;
         dly_en_r <= dly_en_nxt;
         bst_en_r <= bst_en_nxt;
         fail_r   <= fail_nxt;
         bct_r    <= bct_nxt;
         dct_r    <= dct_nxt;
         ihm_r    <= ihm_nxt;
         tsr_r    <= tsr_nxt;
         btm_r    <= btm_nxt;
      end
   end

   // demand group: queue strobes and the sticky overflow flag
   always_comb begin
      // demand capture: a demand in the flush cycle is dropped with the rest
      dq.push      = irq_valid && irq_en_r && !flush;
      dq.push_data = {1'b0, irq_level};
      dq.flush     = flush;
      // overflow set by a full-queue demand; flush clears it
      ovf_nxt = ovf_r;
      if (flush) begin
         ovf_nxt = 1'b0;
      end else if (irq_valid && irq_en_r && dq.full) begin
         ovf_nxt = 1'b1;
      end
      // host read of the queue pops it; message path pops on acceptance
      dq.pop = (reg_rd && reg_addr == scr_pkg::OFS_DEMAND_QUEUE_READ)
               || (msg_req_r && demand_msg_taken);
   end

   always_ff @(posedge ref_clk or posedge rst) begin
      if (rst) begin
         ovf_r <= 1'b0;
      end else if (clk_en) begin
         ovf_r <= ovf_nxt;
      end
   end

   // message group: the request drops for a cycle after each pop, so a stale head is never offered
   always_comb begin
      msg_req_nxt = msg_en_r && dq.nonempty && !flush && !dq.pop;
      // an empty queue's head is stale or never written, so the source keeps its last value
      msg_src_nxt = dq.nonempty ? dq.head : msg_src_r;
   end

   always_ff @(posedge ref_clk or posedge rst) begin
      if (rst) begin
         msg_req_r <= 1'b0;
         msg_src_r <= 4'h0;
      end else if (clk_en) begin
         msg_req_r <= msg_req_nxt;
         msg_src_r <= msg_src_nxt;
      end
   end

   // reset pulse group
   always_comb begin
      // momentary reset, stretched to a minimum width
      rst_cnt_nxt = rst_cnt_r;
      rst_out_nxt = 1'b0;
      if (csr_wr && reg_wdata[scr_pkg::BIT_RESET_PULSE]) begin
         rst_cnt_nxt = PCW'(scr_pkg::RESET_PULSE_CYC);
      end else if (rst_cnt_r != '0) begin
         rst_cnt_nxt = rst_cnt_r - PCW'(1);
      end
      rst_out_nxt = (rst_cnt_nxt != '0);
   end

   always_ff @(posedge ref_clk or posedge rst) begin
      if (rst) begin
         rst_cnt_r <= '0;
         rst_out_r <= 1'b0;
      end else if (clk_en) begin
         rst_cnt_r <= rst_cnt_nxt;
         rst_out_r <= rst_out_nxt;
      end
   end

   // read group
   always_comb begin
      // read views; reserved bits read zero
      csr_view = '0;
      csr_view[scr_pkg::BIT_SELFTEST_OK]     = st_s2_r;
      csr_view[scr_pkg::BIT_DEMAND_OVERFLOW] = ovf_r;
      csr_view[scr_pkg::BIT_DEMAND_PENDING]  = dq.nonempty;
      csr_view[scr_pkg::BIT_DEMAND_MSG_EN]   = msg_en_r;
      csr_view[scr_pkg::BIT_IRQ_DEMAND_EN]   = irq_en_r;
      csr_view[scr_pkg::BIT_TRIG_DELAY_EN]   = dly_en_r;
      csr_view[scr_pkg::BIT_BURST_EN]        = bst_en_r;
      csr_view[scr_pkg::BIT_FAIL_DRIVE]      = fail_r;
      csr_view[scr_pkg::BIT_FAIL_SENSE]      = fail_s2_r;
      rdata_nxt = rdata_r;
      if (reg_rd) begin
         case (reg_addr)
            scr_pkg::OFS_CONTROL_STATUS:    rdata_nxt = {16'h0000, csr_view};
            scr_pkg::OFS_TRANSFER_COUNT:    rdata_nxt = transfer_count_remaining;
            scr_pkg::OFS_DEMAND_QUEUE_READ: rdata_nxt = {28'h0000000, (dq.nonempty ? dq.head : 4'h0)};
            default:                        rdata_nxt = scr_pkg::REG_ZERO;
         endcase
      end
      cdata_nxt = cdata_r;
      if (cfg_rd) begin
         case (cfg_addr)
            scr_pkg::OFS_SUFFIX_HIGH: cdata_nxt = SUFFIX_HIGH;
            scr_pkg::OFS_SUFFIX_LOW:  cdata_nxt = SUFFIX_LOW;
            default:                  cdata_nxt = 16'h0000;
         endcase
      end
   end

   always_ff @(posedge ref_clk or posedge rst) begin
      if (rst) begin
         rdata_r <= 32'h0000_0000;
         cdata_r <= 16'h0000;
      end else if (clk_en) begin
         rdata_r <= rdata_nxt;
         cdata_r <= cdata_nxt;
      end
   end

   assign reg_rdata              = rdata_r;
   assign cfg_rdata              = cdata_r;
   assign demand_msg_req         = msg_req_r;
   assign demand_msg_src         = msg_src_r;
   assign trigger_delay_enable   = dly_en_r;
   assign burst_enable           = bst_en_r;
   assign burst_length_limit     = bct_r;
   assign trigger_delay_count    = dct_r;
   assign irq_handler_mask       = ihm_r;
   assign trigger_source_select  = tsr_r;
   assign broadcast_trigger_mask = btm_r;
   assign fail_line_drive_n      = ~fail_r;
   assign backplane_reset_pulse  = rst_out_r;
endmodule : scr_regs
`default_nettype wire

/* File: sim/scr_regs_props.sv */
// checker: port-level properties of the slot-0 register bank
`timescale 1ns/1ns
`default_nettype none
module scr_regs_props #(
   parameter logic [15:0] SUFFIX_HIGH = 16'h5858, // arbitrary identity value
   parameter logic [15:0] SUFFIX_LOW  = 16'h3030  // arbitrary identity value
) (
   // clock and reset
   input wire logic        ref_clk,
   input wire logic        rst,
   input wire logic        clk_en,
   // register and config ports
   input wire logic        reg_wr,
   input wire logic        reg_rd,
   input wire logic [5:0]  reg_addr,
   input wire logic [31:0] reg_wdata,
   input wire logic [31:0] reg_rdata,
   input wire logic        cfg_rd,
   input wire logic [5:0]  cfg_addr,
   input wire logic [15:0] cfg_rdata,
   input wire logic [31:0] transfer_count_remaining,
   // control outputs
   input wire logic        burst_enable,
   input wire logic        trigger_delay_enable,
   input wire logic [7:0]  burst_length_limit,
   input wire logic        fail_line_drive_n,
   input wire logic        backplane_reset_pulse
);
   default clocking cb @(posedge ref_clk); endclocking
   default disable iff (rst);
   logic       csr_wr;
   logic       rd_ok;
   logic [7:0] pulse_cnt_r;
   assign csr_wr = clk_en && reg_wr && reg_addr == 6'h00;
   assign rd_ok  = clk_en && reg_rd;
   // pulse is too long for a repetition, so its width is counted and judged when it drops
   always_ff @(posedge ref_clk or posedge rst) begin
      if (rst)
         pulse_cnt_r <= 8'h00;
      else if (clk_en)
         pulse_cnt_r <= backplane_reset_pulse ? pulse_cnt_r + 8'h01 : 8'h00;
   end
   rst_start_a: assert property (csr_wr && reg_wdata[0] |=> backplane_reset_pulse)
      else $error("reset pulse did not start");
   pulse_width_a: assert property ($fell(backplane_reset_pulse) |-> int'(pulse_cnt_r) == scr_pkg::RESET_PULSE_CYC)
      else $error("reset pulse width wrong");
   fail_drive_a: assert property (csr_wr |=> fail_line_drive_n == !$past(reg_wdata[2]))
      else $error("fail line drive wrong");
   burst_en_a: assert property (csr_wr |=> burst_enable == $past(reg_wdata[4]))
      else $error("burst enable wrong");
   delay_en_a: assert property (csr_wr |=> trigger_delay_enable == $past(reg_wdata[5]))
      else $error("delay enable wrong");
   burst_limit_a: assert property (clk_en && reg_wr && reg_addr == 6'h04 |=> burst_length_limit == $past(reg_wdata[7:0]))
      else $error("burst limit wrong");
   suffix_id_a: assert property (clk_en && cfg_rd |=> cfg_rdata == ($past(cfg_addr) == 6'h20 ? SUFFIX_HIGH :
      ($past(cfg_addr) == 6'h22 ? SUFFIX_LOW : 16'h0000)))
      else $error("suffix read wrong");
   count_read_a: assert property (rd_ok && reg_addr == 6'h0c |=> reg_rdata == $past(transfer_count_remaining))
      else $error("transfer count read wrong");
   unread_zero_a: assert property (rd_ok && (reg_addr inside {6'h04, 6'h08, 6'h10, 6'h18, 6'h1c, 6'h20, 6'h24}
      || reg_addr >= 6'h28) |=> reg_rdata == 32'h0000_0000)
      else $error("unreadable offset not zero");
   csr_wo_bits_a: assert property (rd_ok && reg_addr == 6'h00 |=> reg_rdata[31:16] == 16'h0000
      && !reg_rdata[11] && !reg_rdata[0])
      else $error("write-only control bits read back");
   cover property (csr_wr && reg_wdata[0]);
   cover property (csr_wr && reg_wdata[11]);
   cover property (rd_ok && reg_addr == 6'h14);
endmodule : scr_regs_props
bind scr_regs scr_regs_props #(.SUFFIX_HIGH(SUFFIX_HIGH), .SUFFIX_LOW(SUFFIX_LOW)) u_props (
   .ref_clk(ref_clk), .rst(rst), .clk_en(clk_en), .reg_wr(reg_wr), .reg_rd(reg_rd), .reg_addr(reg_addr),
   .reg_wdata(reg_wdata), .reg_rdata(reg_rdata), .cfg_rd(cfg_rd), .cfg_addr(cfg_addr), .cfg_rdata(cfg_rdata),
   .transfer_count_remaining(transfer_count_remaining), .burst_enable(burst_enable),
   .trigger_delay_enable(trigger_delay_enable), .burst_length_limit(burst_length_limit),
   .fail_line_drive_n(fail_line_drive_n), .backplane_reset_pulse(backplane_reset_pulse));
`default_nettype wire

/* File: sim/scr_bp_model.sv */
// backplane model: wired fail line and demand message consumer
`timescale 1ns/1ns
`default_nettype none
module scr_bp_model (
   // clock and reset
   input  wire logic ref_clk,
   input  wire logic rst,
   // backplane side
   input  wire logic fail_line_drive_n,
   input  wire logic other_fail,
   input  wire logic slow,
   input  wire logic demand_msg_req,
   output logic      fail_line_in,
   output logic      demand_msg_taken
);
   logic [2:0] wait_r;
   // wired line: any card pulling it low shows as failed, the pull-up leaves it idle
   assign fail_line_in = !fail_line_drive_n || other_fail;
   // at least two idle cycles after each take so a stale request is never taken twice
   always_ff @(posedge ref_clk or posedge rst) begin
      if (rst) begin
         wait_r           <= 3'h0;
         demand_msg_taken <= 1'b0;
      end else begin
         demand_msg_taken <= 1'b0;
         if (!demand_msg_req || demand_msg_taken)
            wait_r <= 3'h0;
         else if (wait_r == (slow ? 3'h5 : 3'h2)) begin
            demand_msg_taken <= 1'b1;
            wait_r           <= 3'h0;
         end else
            wait_r <= wait_r + 3'h1;
      end
   end
endmodule : scr_bp_model
`default_nettype wire

/* File: sim/slot0_control_status_regs_tb.sv */
// testbench: map, control bits, reset pulse and demand queue of the slot-0 register bank
`timescale 1ns/1ns
`default_nettype none
module slot0_control_status_regs_tb;
   localparam logic [15:0] SFX_H = 16'h5a59; // arbitrary identity value
   localparam logic [15:0] SFX_L = 16'h3837; // arbitrary identity value
   localparam int          DEPTH = 4;
   logic        ref_clk = 0, rst = 1, clk_en = 1, reg_wr = 0, reg_rd = 0, cfg_rd = 0;
   logic        selftest_ok = 1, irq_valid = 0, other_fail = 0, slow = 0;
   logic [5:0]  reg_addr = 0, cfg_addr = 0;
   logic [2:0]  irq_level = 0;
   logic [31:0] reg_wdata = 0, transfer_count_remaining = 32'h89ab_cdef;
   logic [31:0] reg_rdata, irq_handler_mask, trigger_source_select, broadcast_trigger_mask;
   logic [15:0] cfg_rdata, trigger_delay_count;
   logic [7:0]  burst_length_limit;
   logic [3:0]  demand_msg_src;
   logic        demand_msg_req, trigger_delay_enable, burst_enable, fail_line_drive_n;
   logic        backplane_reset_pulse, fail_line_in, demand_msg_taken;
   int          num_errors = 0, checks = 0;

   scr_regs #(.SUFFIX_HIGH(SFX_H), .SUFFIX_LOW(SFX_L), .DEPTH(DEPTH)) uut (
      .ref_clk(ref_clk), .rst(rst), .clk_en(clk_en), .reg_wr(reg_wr), .reg_rd(reg_rd), .reg_addr(reg_addr),
      .reg_wdata(reg_wdata), .reg_rdata(reg_rdata), .cfg_rd(cfg_rd), .cfg_addr(cfg_addr), .cfg_rdata(cfg_rdata),
      .selftest_ok(selftest_ok), .irq_valid(irq_valid), .irq_level(irq_level), .fail_line_in(fail_line_in),
      .transfer_count_remaining(transfer_count_remaining), .demand_msg_taken(demand_msg_taken),
      .demand_msg_req(demand_msg_req), .demand_msg_src(demand_msg_src),
      .trigger_delay_enable(trigger_delay_enable), .burst_enable(burst_enable),
      .burst_length_limit(burst_length_limit), .trigger_delay_count(trigger_delay_count),
      .irq_handler_mask(irq_handler_mask), .trigger_source_select(trigger_source_select),
      .broadcast_trigger_mask(broadcast_trigger_mask), .fail_line_drive_n(fail_line_drive_n),
      .backplane_reset_pulse(backplane_reset_pulse));
   scr_bp_model u_bp (.ref_clk(ref_clk), .rst(rst), .fail_line_drive_n(fail_line_drive_n),
      .other_fail(other_fail), .slow(slow), .demand_msg_req(demand_msg_req), .fail_line_in(fail_line_in),
      .demand_msg_taken(demand_msg_taken));

   always #5 ref_clk = ~ref_clk;

   task automatic check(input logic [31:0] got, input logic [31:0] exp, input string what);
      checks++;
      if (got !== exp) begin
         num_errors++;
         $display("ERROR %0t: %s got %h expected %h", $time, what, got, exp);
      end
   endtask : check

   // every access is a whole 32-bit word
   task automatic wr(input logic [5:0] a, input logic [31:0] d);
      @(negedge ref_clk);
      {reg_wr, reg_addr, reg_wdata} = {1'b1, a, d};
      @(negedge ref_clk);
      reg_wr = 0;
   endtask : wr

   task automatic rd(input logic [5:0] a, input logic [31:0] exp, input string what);
      @(negedge ref_clk);
      {reg_rd, reg_addr} = {1'b1, a};
      @(negedge ref_clk);
      reg_rd = 0;
      check(reg_rdata, exp, what);
   endtask : rd

   task automatic irq(input logic [2:0] l);
      @(negedge ref_clk);
      {irq_valid, irq_level} = {1'b1, l};
      @(negedge ref_clk);
      irq_valid = 0;
   endtask : irq

   task automatic t_map();
      logic [5:0] none[9] = '{6'h04, 6'h08, 6'h10, 6'h18, 6'h1c, 6'h20, 6'h24, 6'h28, 6'h2c};
      logic [5:0] ca[3]   = '{6'h20, 6'h22, 6'h1e};
      logic [15:0] ce[3]  = '{SFX_H, SFX_L, 16'h0000};
      check({fail_line_drive_n, backplane_reset_pulse}, 32'h2, "idle outputs");
      rd(6'h00, 32'h0000_8000, "csr after reset");
      rd(6'h0c, 32'h89ab_cdef, "transfer count");
      foreach (none[i]) rd(none[i], 32'h0, "unreadable offset");
      foreach (ca[i]) begin
         @(negedge ref_clk);
         {cfg_rd, cfg_addr} = {1'b1, ca[i]};
         @(negedge ref_clk);
         cfg_rd = 0;
         check({16'h0, cfg_rdata}, {16'h0, ce[i]}, "suffix");
      end
   endtask : t_map

   task automatic t_ctrl();
      wr(6'h00, 32'h0000_02b4);
      repeat (3) @(negedge ref_clk);
      rd(6'h00, 32'h0000_82b6, "controls set");
      check({fail_line_drive_n, burst_enable, trigger_delay_enable}, 32'h3, "control pins");
      wr(6'h04, 32'hffff_ff80);
      wr(6'h08, 32'h1234_5678);
      wr(6'h18, 32'ha5a5_0f0f);
      wr(6'h20, 32'h0000_00c3);
      wr(6'h24, 32'h8000_0001);
      check({24'h0, burst_length_limit}, 32'h80, "burst limit");
      check({16'h0, trigger_delay_count}, 32'h5678, "delay count");
      check(irq_handler_mask ^ trigger_source_select, 32'ha5a5_0fcc, "masks");
      check(broadcast_trigger_mask, 32'h8000_0001, "bcast mask");
      clk_en = 0;
      wr(6'h04, 32'h0000_0011);
      check({24'h0, burst_length_limit}, 32'h80, "write frozen by clock enable");
      clk_en = 1;
      wr(6'h00, 32'h0);
      other_fail = 1;
      repeat (3) @(negedge ref_clk);
      rd(6'h00, 32'h0000_8002, "fail from other card");
      check({fail_line_drive_n, burst_enable, trigger_delay_enable}, 32'h4, "controls off");
      other_fail = 0;
   endtask : t_ctrl

   task automatic t_pulse();
      int n = 0;
      wr(6'h00, 32'h0000_0001);
      repeat (40) begin
         if (backplane_reset_pulse) n++;
         @(negedge ref_clk);
      end
      check(n, scr_pkg::RESET_PULSE_CYC, "reset pulse width");
      rd(6'h00, 32'h0000_8000, "pulse bit not held");
   endtask : t_pulse

   task automatic t_demand();
      int n = 0;
      irq(3'h5);
      rd(6'h00, 32'h0000_8000, "store disabled");
      wr(6'h00, 32'h0000_0080);
      for (int i = 1; i <= DEPTH; i++) irq(i[2:0]);
      rd(6'h00, 32'h0000_8480, "queue full");
      check({31'h0, demand_msg_req}, 32'h0, "no message while disabled");
      irq(3'h7);
      rd(6'h00, 32'h0000_9480, "overflow");
      rd(6'h14, 32'h0000_0001, "oldest demand");
      rd(6'h00, 32'h0000_9480, "overflow sticks");
      wr(6'h00, 32'h0000_0880);
      rd(6'h00, 32'h0000_8080, "after flush");
      slow = 1;
      irq(3'h2);
      irq(3'h6);
      wr(6'h00, 32'h0000_0200);
      repeat (60) begin
         @(negedge ref_clk);
         if (demand_msg_taken) begin
            check({27'h0, demand_msg_req, demand_msg_src}, n == 0 ? 32'h12 : 32'h16, "demand source");
            n++;
         end
      end
      check(n, 32'h2, "messages sent");
      rd(6'h00, 32'h0000_8200, "drained");
   endtask : t_demand

   task automatic t_reset();
      wr(6'h00, 32'h0000_0084);
      irq(3'h3);
      rd(6'h00, 32'h0000_8486, "before mid-run reset");
      @(negedge ref_clk);
      rst = 1;
      @(negedge ref_clk);
      rst = 0;
      check({fail_line_drive_n, demand_msg_req, backplane_reset_pulse}, 32'h4, "outputs after reset");
      repeat (3) @(negedge ref_clk);
      rd(6'h00, 32'h0000_8000, "csr cleared by reset");
   endtask : t_reset

   task automatic final_report();
      if (num_errors == 0 && checks > 0)
         $display("== PASSED ==");
      else
         $display("== FAILED ==");
      $finish;
   endtask : final_report

   initial begin
      #200000;
      num_errors++;
      final_report();
   end

   initial begin
      repeat (8) @(negedge ref_clk);
      rst = 0;
      // selftest flag passes two synchroniser stages before the first read
      repeat (3) @(negedge ref_clk);
      t_map();
      t_ctrl();
      t_pulse();
      t_demand();
      t_reset();
      final_report();
   end
endmodule : slot0_control_status_regs_tb
`default_nettype wire
